// [logic/fstop_pkg.sv]
// Package: constants, register map and state types of the forced stop block
package fstop_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int N_OUT = 6;
   localparam int N_TMR = 3;
   localparam int N_CMP = 6;
   localparam int CTL_W = 18;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTL_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CLKEN = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_SWCMD = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h28;

   ////////////////////////////////////////////////////////////////////////////
   // Per-output control register fields
   localparam int F_S1_COMP = 0;
   localparam int F_S2_COMP = 6;
   localparam int F_S2_PIN = 12;
   localparam int F_S2_MODE = 13;
   localparam int F_S1_LVL = 14;
   localparam int F_S2_LVL = 16;
   localparam int F_S1_SYNC = 17;

   // Software command and status fields
   localparam int F_SW_START = 0;
   localparam int F_SW_CANCEL = 6;
   localparam int F_ST_STOP1 = 0;
   localparam int F_ST_STOP2 = 6;

   // Stopped level codes of stop function 1
   localparam logic [1:0] LVL_HIZ = 2'h0;
   localparam logic [1:0] LVL_LOW = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;

   // Comparators reaching each output, output 5 leftmost
   localparam logic [N_OUT-1:0][N_CMP-1:0] ROUTE_COMP = {
      6'h31, 6'h31, 6'h0D, 6'h0D, 6'h07, 6'h07};

   ////////////////////////////////////////////////////////////////////////////
   // State types
   typedef struct packed {
      logic [N_OUT-1:0][CTL_W-1:0] ctl;
      logic [N_TMR-1:0] en;
      logic [11:0] stat;
      logic [11:0] mask;
      logic [N_CMP-1:0] comp_prev;
      logic pin_prev;
      logic prime;
      logic [DATA_W-1:0] rdata;
      logic irq;
   } top_state_t;

   typedef struct packed {
      logic stop1;
      logic pend;
      logic stop2;
      logic rev;
      logic val;
      logic oe;
   } chan_state_t;

   // Reset values
   localparam top_state_t TOP_RST = '0;
   localparam chan_state_t CHAN_RST = 6'h03;

endpackage : fstop_pkg

// [logic/fstop_channel.sv]
// One output channel: stop state of both functions and the output mux
`timescale 1ns/1ps
`default_nettype none
module fstop_channel
   import fstop_pkg::*;
(
   input wire logic i_clk,          // System clock
   input wire logic i_resetn,       // Synchronous reset, active low
   input wire logic i_enable,       // Timer clock enable
   input wire logic i_start1,       // Stop 1 start pulse
   input wire logic i_cancel1,      // Stop 1 software cancel pulse
   input wire logic i_sync1,        // Stop 1 cancel waits for period
   input wire logic i_start2,       // Stop 2 start pulse
   input wire logic i_rev2,         // Stop 2 reverse edge pulse
   input wire logic i_mode2,        // Stop 2 cancel mode
   input wire logic i_period,       // Counter period boundary pulse
   input wire logic i_pwm,          // Normal pulse-width output
   input wire logic [1:0] i_lvl1,   // Stop 1 stopped level
   input wire logic i_lvl2,         // Stop 2 stopped level
   output logic o_stop1,            // Stop 1 active
   output logic o_stop2,            // Stop 2 active
   output logic o_val,              // Pin output value
   output logic o_oe                // Pin output enable
);

   chan_state_t ch_q;
   chan_state_t ch_d;

   // Next state; a start always wins over a cancel in the same cycle
   always_comb begin
      ch_d = ch_q;
      if (i_start1) begin
         ch_d.stop1 = 1'b1;
         ch_d.pend = 1'b0;
      end else if (ch_q.stop1) begin
         // A pending cancel only releases on a later boundary
         if (ch_q.pend && i_period) begin
            ch_d.stop1 = 1'b0;
            ch_d.pend = 1'b0;
         end else if (i_cancel1) begin
            if (i_sync1) begin
               ch_d.pend = 1'b1;
            end else begin
               ch_d.stop1 = 1'b0;
               ch_d.pend = 1'b0;
            end
         end
      end
      if (i_start2) begin
         ch_d.stop2 = 1'b1;
         ch_d.rev = 1'b0;
      end else if (ch_q.stop2) begin
         if (i_period && (!i_mode2 || ch_q.rev)) begin
            ch_d.stop2 = 1'b0;
            ch_d.rev = 1'b0;
         end else if (i_rev2) begin
            ch_d.rev = 1'b1;
         end
      end
      // A disabled timer sits in its initial status
      if (!i_enable) begin
         ch_d.stop1 = 1'b0;
         ch_d.pend = 1'b0;
         ch_d.stop2 = 1'b0;
         ch_d.rev = 1'b0;
      end
      // Output mux; stop 1 outranks stop 2 since only it can float the pin
      ch_d.oe = 1'b1;
      ch_d.val = i_pwm;
      if (ch_q.stop1) begin
         case (i_lvl1)
            LVL_LOW: ch_d.val = 1'b0;
            LVL_HIGH: ch_d.val = 1'b1;
            default: begin
               ch_d.oe = 1'b0;
               ch_d.val = 1'b0;
            end
         endcase
      end else if (ch_q.stop2) begin
         ch_d.val = i_lvl2;
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         ch_q <= CHAN_RST;
      end else begin
         ch_q <= ch_d;
      end
   end

   assign o_stop1 = ch_q.stop1;
   assign o_stop2 = ch_q.stop2;
   assign o_val = ch_q.val;
   assign o_oe = ch_q.oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   a_edge_hold_wait:
   assert property ((ch_q.stop2 && i_mode2 && !ch_q.rev && i_enable)
      |=> o_stop2)
      else $error("stop 2 released before reverse edge");

   a_edge_release:
   assert property ((ch_q.stop2 && i_mode2 && ch_q.rev && i_period &&
      !i_start2 && i_enable) |=> !o_stop2)
      else $error("stop 2 not released after reverse edge");

endmodule : fstop_channel
`default_nettype wire

// [logic/timer_output_forced_stop.sv]
// Forced stop of six timer outputs on trigger edges, with register port
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module timer_output_forced_stop
   import fstop_pkg::*;
(
   input wire logic I_CLK_SYS,                 // System clock, 125 MHz
   input wire logic I_RESETN,                  // Synchronous reset, low
   input wire logic [ADDR_W-1:0] I_ADDR,       // Register byte address
   input wire logic [DATA_W-1:0] I_WDATA,      // Register write data
   input wire logic I_WR,                      // Write strobe
   input wire logic I_RD,                      // Read strobe
   output logic [DATA_W-1:0] O_RDATA,          // Read data, next cycle
   input wire logic [N_CMP-1:0] I_COMP,        // Comparator outputs
   input wire logic I_EXT_TRIGGER_PIN_A,       // External trigger pin
   input wire logic [N_TMR-1:0] I_PERIOD,      // Period boundary pulses
   input wire logic [N_OUT-1:0] I_PWM,         // Normal timer outputs
   output logic [N_OUT-1:0] O_PWM_TIMER_OUTPUT, // Pin output values
   output logic [N_OUT-1:0] O_PWM_TIMER_OE,    // Pin output enables
   output logic O_IRQ                          // Interrupt, level
);

   top_state_t st_q;
   top_state_t st_d;

   logic [N_CMP-1:0] comp_rise;
   logic [N_CMP-1:0] comp_fall;
   logic pin_edge;
   logic sw_wr;
   logic ctl_hit;
   logic [2:0] ctl_idx;
   logic [N_OUT-1:0] start1_v;
   logic [N_OUT-1:0] start2_v;
   logic [N_OUT-1:0] stop1_v;
   logic [N_OUT-1:0] stop2_v;

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection; prime masks the first cycle after reset so that a
   // comparator already high at reset is not taken for a rising edge
   assign comp_rise = {N_CMP{st_q.prime}} & I_COMP & ~st_q.comp_prev;
   assign comp_fall = {N_CMP{st_q.prime}} & ~I_COMP & st_q.comp_prev;
   assign pin_edge = st_q.prime &
      (I_EXT_TRIGGER_PIN_A ^ st_q.pin_prev);

   // Register decode
   assign sw_wr = I_WR && (I_ADDR == OFS_SWCMD);
   assign ctl_hit = (I_ADDR < OFS_CLKEN) && (I_ADDR[1:0] == 2'h0);
   assign ctl_idx = I_ADDR[4:2];

   ////////////////////////////////////////////////////////////////////////////
   // Per-output trigger routing and channel logic
   for (genvar k = 0; k < N_OUT; k++) begin : g_chan
      logic en;
      logic [CTL_W-1:0] ctl;
      logic rev2;
      assign en = st_q.en[k/2];
      assign ctl = st_q.ctl[k];
      // Pin A never reaches stop 1; it starts stop 2 only when F_S2_PIN is set
      assign start1_v[k] = en && ((|(comp_rise & ROUTE_COMP[k] &
         ctl[F_S1_COMP +: N_CMP])) ||
         (sw_wr && I_WDATA[F_SW_START + k]));
      assign start2_v[k] = en && ((|(comp_rise & ROUTE_COMP[k] &
         ctl[F_S2_COMP +: N_CMP])) ||
         (pin_edge && ctl[F_S2_PIN]));
      // Any edge of the pin also restarts stop 2, so only a comparator fall marks the reverse edge
      assign rev2 = (|(comp_fall & ROUTE_COMP[k] &
         ctl[F_S2_COMP +: N_CMP])) ||
         (pin_edge && ctl[F_S2_PIN]);

      fstop_channel u_chan (
         .i_clk(I_CLK_SYS),
         .i_resetn(I_RESETN),
         .i_enable(en),
         .i_start1(start1_v[k]),
         .i_cancel1(sw_wr && I_WDATA[F_SW_CANCEL + k]),
         .i_sync1(ctl[F_S1_SYNC]),
         .i_start2(start2_v[k]),
         .i_rev2(rev2),
         .i_mode2(ctl[F_S2_MODE]),
         .i_period(I_PERIOD[k/2]),
         .i_pwm(I_PWM[k]),
         .i_lvl1(ctl[F_S1_LVL +: 2]),
         .i_lvl2(ctl[F_S2_LVL]),
         .o_stop1(stop1_v[k]),
         .o_stop2(stop2_v[k]),
         .o_val(O_PWM_TIMER_OUTPUT[k]),
         .o_oe(O_PWM_TIMER_OE[k])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file, status and interrupt next state
   always_comb begin
      st_d = st_q;
      st_d.prime = 1'b1;
      st_d.comp_prev = I_COMP;
      st_d.pin_prev = I_EXT_TRIGGER_PIN_A;
      st_d.rdata = '0;
      if (I_WR) begin
         if (ctl_hit && st_q.en[ctl_idx[2:1]]) begin
            st_d.ctl[ctl_idx] = I_WDATA[CTL_W-1:0];
         end
         case (I_ADDR)
            OFS_CLKEN: st_d.en = I_WDATA[N_TMR-1:0];
            OFS_IRQ_MASK: st_d.mask = I_WDATA[11:0];
            default: ;
         endcase
      end
      // A timer without its clock enable keeps its controls at default
      for (int k = 0; k < N_OUT; k++) begin
         if (!st_d.en[k/2]) begin
            st_d.ctl[k] = '0;
         end
      end
      // Sticky events; a new start beats a write-one clear
      st_d.stat = st_q.stat & ~((I_WR && I_ADDR == OFS_IRQ_STAT) ?
         I_WDATA[11:0] : 12'h000);
      st_d.stat = st_d.stat | {start2_v, start1_v};
      st_d.irq = |(st_d.stat & st_d.mask);
      // Read data stands only in the cycle after the strobe
      if (I_RD) begin
         if (ctl_hit) begin
            st_d.rdata = DATA_W'(st_q.ctl[ctl_idx]);
         end else begin
            case (I_ADDR)
               OFS_CLKEN: st_d.rdata = DATA_W'(st_q.en);
               OFS_STATUS: st_d.rdata = DATA_W'({stop2_v, stop1_v});
               OFS_IRQ_STAT: st_d.rdata = DATA_W'(st_q.stat);
               OFS_IRQ_MASK: st_d.rdata = DATA_W'(st_q.mask);
               default: st_d.rdata = '0;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         st_q <= TOP_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign O_RDATA = st_q.rdata;
   assign O_IRQ = st_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on output 0
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);

   sequence s_sync_cancel;
      stop1_v[0] && st_q.en[0] && st_q.ctl[0][F_S1_SYNC] && sw_wr &&
      I_WDATA[F_SW_CANCEL] && !I_WDATA[F_SW_START] && $stable(I_COMP) &&
      !I_PERIOD[0];
   endsequence

   sequence s_boundary_quiet;
      I_PERIOD[0] && st_q.en[0] && !sw_wr && $stable(I_COMP);
   endsequence

   a_steady_no_start:
   assert property ((!stop1_v[0] && !stop2_v[0] && $stable(I_COMP) &&
      $stable(I_EXT_TRIGGER_PIN_A) && !sw_wr) |=>
      (!stop1_v[0] && !stop2_v[0]))
      else $error("stop began without an edge");

   a_comp_start:
   assert property ((st_q.en[0] && st_q.prime && st_q.ctl[0][F_S1_COMP] &&
      $rose(I_COMP[0])) |=> stop1_v[0])
      else $error("comparator edge did not start stop 1");

   a_route_isolate:
   assert property (($rose(I_COMP[3]) && $stable(I_COMP[2:0]) &&
      $stable(I_COMP[5:4]) && !stop1_v[0] && !sw_wr) |=> !stop1_v[0])
      else $error("unrouted comparator started stop 1");

   a_pin_no_stop1:
   assert property ((!stop1_v[0] && !sw_wr && $stable(I_COMP) &&
      $changed(I_EXT_TRIGGER_PIN_A)) |=> !stop1_v[0])
      else $error("pin edge started stop 1");

   a_pin_fall_stop2:
   assert property ((st_q.en[0] && st_q.prime && st_q.ctl[0][F_S2_PIN] &&
      $fell(I_EXT_TRIGGER_PIN_A)) |=> stop2_v[0])
      else $error("pin falling edge did not start stop 2");

   a_sw_start:
   assert property ((sw_wr && I_WDATA[F_SW_START] && st_q.en[0])
      |=> stop1_v[0])
      else $error("software start ignored");

   a_sw_cancel:
   assert property ((stop1_v[0] && st_q.en[0] && sw_wr &&
      I_WDATA[F_SW_CANCEL] && !I_WDATA[F_SW_START] &&
      !st_q.ctl[0][F_S1_SYNC] && $stable(I_COMP)) |=> !stop1_v[0])
      else $error("software cancel ignored");

   a_sync_hold:
   assert property (s_sync_cancel |=> stop1_v[0])
      else $error("synchronised cancel released early");

   a_sync_release:
   assert property (s_sync_cancel ##1 s_boundary_quiet |=> !stop1_v[0])
      else $error("synchronised cancel missed the boundary");

   a_auto_release:
   assert property (((stop2_v[0] && !st_q.ctl[0][F_S2_MODE] &&
      $stable(I_EXT_TRIGGER_PIN_A)) and s_boundary_quiet) |=> !stop2_v[0])
      else $error("stop 2 not released at boundary");

   a_hiz_level:
   assert property ((stop1_v[0] &&
      st_q.ctl[0][F_S1_LVL +: 2] == LVL_HIZ) |=> !O_PWM_TIMER_OE[0])
      else $error("stop 1 did not float the pin");

   a_low_override:
   assert property ((stop1_v[0] && st_q.ctl[0][F_S1_LVL +: 2] == LVL_LOW)
      |=> (O_PWM_TIMER_OE[0] && !O_PWM_TIMER_OUTPUT[0]))
      else $error("stop 1 low level not driven");

   a_stop2_level:
   assert property ((stop2_v[0] && !stop1_v[0]) |=> (O_PWM_TIMER_OE[0] &&
      O_PWM_TIMER_OUTPUT[0] == $past(st_q.ctl[0][F_S2_LVL])))
      else $error("stop 2 level wrong or floating");

   a_clken_reads:
   assert property ((I_RD && I_ADDR == OFS_CTL_BASE && !st_q.en[0])
      |=> O_RDATA == '0)
      else $error("disabled control register read non-default");

endmodule : timer_output_forced_stop
`default_nettype wire

// [verif/fstop_sense_model.sv]
// Sense circuit model: comparator outputs, trigger pin and period pulses
`timescale 1ns/1ps
`default_nettype none
module fstop_sense_model
   import fstop_pkg::*;
(
   input wire logic i_clk,                     // System clock
   input wire logic i_resetn,                  // Synchronous reset, low
   input wire logic i_slow,                    // Answer one cycle later
   input wire logic [N_CMP-1:0] i_comp_req,    // Wanted comparator levels
   input wire logic i_pin_req,                 // Wanted pin level
   input wire logic [N_TMR-1:0] i_period_req,  // Wanted period pulses
   output logic [N_CMP-1:0] o_comp,            // Comparator outputs
   output logic o_pin,                         // Trigger pin level
   output logic [N_TMR-1:0] o_period           // Period boundary pulses
);
   logic [N_CMP:0] near_q;
   logic [N_CMP:0] far_q;

   ////////////////////////////////////////////////////////////////////////////
   // Two sense stages; the slow path mimics a sluggish sense amplifier
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         near_q <= '0;
         far_q <= '0;
         o_period <= '0;
      end else begin
         near_q <= {i_pin_req, i_comp_req};
         far_q <= near_q;
         o_period <= i_period_req; // One cycle wide, as the timer makes them
      end
   end

   // Levels hold steady between commands, so only commanded edges occur
   assign {o_pin, o_comp} = i_slow ? far_q : near_q;
endmodule : fstop_sense_model
`default_nettype wire

// [verif/testbench.sv]
// Testbench: scenarios for the forced stop block and its register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
   n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   import fstop_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic slow = 1'b0;
   logic [N_CMP-1:0] comp_req = '0;
   logic pin_req = 1'b0;
   logic [N_TMR-1:0] per_req = '0;
   logic [N_OUT-1:0] pwm = '0;
   wire logic [DATA_W-1:0] rdata;
   wire logic [N_CMP-1:0] comp;
   wire logic pin;
   wire logic [N_TMR-1:0] period;
   wire logic [N_OUT-1:0] val;
   wire logic [N_OUT-1:0] oe;
   wire logic irq;
   int n_mismatch = 0;
   int n_checks = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Block, far side model and clock
   timer_output_forced_stop DUT (.I_CLK_SYS(clk), .I_RESETN(resetn),
      .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_COMP(comp), .I_EXT_TRIGGER_PIN_A(pin), .I_PERIOD(period),
      .I_PWM(pwm), .O_PWM_TIMER_OUTPUT(val), .O_PWM_TIMER_OE(oe),
      .O_IRQ(irq));
   fstop_sense_model sense (.i_clk(clk), .i_resetn(resetn), .i_slow(slow),
      .i_comp_req(comp_req), .i_pin_req(pin_req), .i_period_req(per_req),
      .o_comp(comp), .o_pin(pin), .o_period(period));
   always #4 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycles and stimulus helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so look there
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd_chk

   task automatic drive(input logic [5:0] c, input logic p);
      @(posedge clk);
      comp_req <= c;
      pin_req <= p;
      cyc(5);
   endtask : drive

   task automatic pulse(input logic [2:0] t);
      @(posedge clk);
      per_req <= t;
      @(posedge clk);
      per_req <= '0;
      cyc(3);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic sc_clken;
      wr_reg(OFS_CTL_BASE, 32'h0000_0001);
      rd_chk(OFS_CTL_BASE, 32'h0000_0000);
      wr_reg(OFS_CLKEN, 32'h0000_0007);
      wr_reg(OFS_CTL_BASE, 32'h0000_0001);
      rd_chk(OFS_CTL_BASE, 32'h0000_0001);
      rd_chk(8'h40, 32'h0000_0000);
   endtask : sc_clken

   // Each stop 1 level on output 0, cancelled by software while comp 0 stays
   task automatic sc_levels;
      logic [1:0] lv [3];
      lv = '{LVL_HIZ, LVL_LOW, LVL_HIGH};
      for (int i = 0; i < 3; i++) begin
         wr_reg(OFS_CTL_BASE, {16'h0000, lv[i], 14'h0001});
         pwm <= (lv[i] == LVL_HIGH) ? 6'h00 : 6'h3F;
         drive(6'h01, 1'b0);
         rd_chk(OFS_STATUS, 32'h0000_0001);
         `CHK(oe[0], (lv[i] != LVL_HIZ))
         if (lv[i] != LVL_HIZ) `CHK(val[0], (lv[i] == LVL_HIGH))
         cyc(6);
         rd_chk(OFS_STATUS, 32'h0000_0001);
         wr_reg(OFS_SWCMD, 32'h0000_0040);
         cyc(6);
         rd_chk(OFS_STATUS, 32'h0000_0000);
         rd_chk(OFS_STATUS, 32'h0000_0000);
         drive(6'h00, 1'b0);
      end
   endtask : sc_levels

   // Comparator 1 does not reach output 2, comparator 3 does
   task automatic sc_route;
      wr_reg(OFS_CTL_BASE, 32'h0000_0000);
      wr_reg(OFS_CTL_BASE + 8'h08, 32'h0000_403F);
      drive(6'h02, 1'b0);
      rd_chk(OFS_STATUS, 32'h0000_0000);
      drive(6'h0A, 1'b0);
      rd_chk(OFS_STATUS, 32'h0000_0004);
      wr_reg(OFS_SWCMD, 32'h0000_0100);
      wr_reg(OFS_CTL_BASE + 8'h08, 32'h0000_0000);
      drive(6'h00, 1'b0);
   endtask : sc_route

   // Software start, then a cancel that waits for the period boundary
   task automatic sc_sw_sync;
      wr_reg(OFS_CTL_BASE + 8'h04, 32'h0002_4000);
      wr_reg(OFS_SWCMD, 32'h0000_0002);
      rd_chk(OFS_STATUS, 32'h0000_0002);
      wr_reg(OFS_SWCMD, 32'h0000_0080);
      cyc(6);
      rd_chk(OFS_STATUS, 32'h0000_0002);
      pulse(3'h1);
      rd_chk(OFS_STATUS, 32'h0000_0000);
   endtask : sc_sw_sync

   // Pin A both edges start stop 2 of output 3; released at next period
   task automatic sc_stop2_auto;
      wr_reg(OFS_CTL_BASE + 8'h0C, 32'h0001_1000);
      pwm <= 6'h00;
      for (int i = 0; i < 2; i++) begin
         drive(6'h00, (i == 0));
         rd_chk(OFS_STATUS, 32'h0000_0200);
         `CHK({oe[3], val[3]}, 2'b11)
         pulse(3'h2);
         rd_chk(OFS_STATUS, 32'h0000_0000);
      end
   endtask : sc_stop2_auto

   // Edge mode on output 4 with a slow sensor: needs the falling edge first
   task automatic sc_stop2_edge;
      @(posedge clk);
      slow <= 1'b1;
      wr_reg(OFS_CTL_BASE + 8'h10, 32'h0000_2040);
      drive(6'h01, 1'b0);
      rd_chk(OFS_STATUS, 32'h0000_0400);
      pulse(3'h4);
      rd_chk(OFS_STATUS, 32'h0000_0400);
      drive(6'h00, 1'b0);
      pulse(3'h4);
      rd_chk(OFS_STATUS, 32'h0000_0000);
   endtask : sc_stop2_edge

   // Start events held sticky; the mask gates the line, write one clears
   task automatic sc_irq;
      rd_chk(OFS_IRQ_STAT, 32'h0000_0607);
      `CHK(irq, 1'b0)
      wr_reg(OFS_IRQ_MASK, 32'h0000_0001);
      cyc(3);
      `CHK(irq, 1'b1)
      wr_reg(OFS_IRQ_STAT, 32'h0000_0001);
      cyc(3);
      `CHK(irq, 1'b0)
      rd_chk(OFS_IRQ_STAT, 32'h0000_0606);
   endtask : sc_irq

   // Output 0: software start, a synchronised cancel whose boundary comes
   // in the very next cycle, then pin A edges in auto mode
   task automatic sc_out0;
      wr_reg(OFS_CTL_BASE, 32'h0003_1000);
      wr_reg(OFS_SWCMD, 32'h0000_0001);
      rd_chk(OFS_STATUS, 32'h0000_0001);
      `CHK(irq, 1'b1)
      @(posedge clk);
      addr <= OFS_SWCMD;
      wdata <= 32'h0000_0040;
      wr <= 1'b1;
      per_req <= 3'h1;
      @(posedge clk);
      wr <= 1'b0;
      per_req <= 3'h0;
      rd_chk(OFS_STATUS, 32'h0000_0000);
      drive(6'h00, 1'b1);
      rd_chk(OFS_STATUS, 32'h0000_0240);
      `CHK({oe[0], val[0]}, 2'b11)
      pulse(3'h3);
      rd_chk(OFS_STATUS, 32'h0000_0000);
      drive(6'h00, 1'b0);
      rd_chk(OFS_STATUS, 32'h0000_0240);
      pulse(3'h3);
      rd_chk(OFS_STATUS, 32'h0000_0000);
   endtask : sc_out0

   ////////////////////////////////////////////////////////////////////////////
   // Verdict, watchdog and main sequence
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      pwm <= 6'h2A;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      cyc(3);
      `CHK(oe, 6'h3F)
      `CHK(val, 6'h2A)
      sc_clken();
      sc_levels();
      sc_route();
      sc_sw_sync();
      sc_stop2_auto();
      sc_stop2_edge();
      sc_irq();
      sc_out0();
      tally_and_finish();
   end
endmodule : testbench
`undef CHK
`default_nettype wire
